// ### hw/nfh_cfg.svh
// Constants for the flash host sequencer: commands, layout and timing
// Contract
// [RULE_01] Command byte latched on write strobe rise
// [RULE_02] Address bytes latched on write strobe rise
// [RULE_03] Read strobe fall outputs byte, advances column
// [RULE_04] Ready/busy low while operation runs
// [RULE_05] Latch enables and strobes select bus mode
// [RULE_06] Write-protect low blocks program and erase
// [RULE_07] Page load busy for at most 10 us
// [RULE_08] Spare-select high hides 16-byte spare region
// [RULE_09] At most 2 main, 3 spare programs; counts are kept for the most recent page only
// [RULE_10] Page end in sequential read goes busy; the sequencer reads len_r bytes and takes no busy wait at a page end
// [RULE_11] End read: chip select high 100 ns
// [RULE_12] Deselect during page load aborts, returns ready
// [RULE_13] Reset command always busy, at most 5 us
// [RULE_14] Block zero always valid, never marked bad
// [RULE_15] Erased locations read as all ones
// [RULE_16] Non-ones at column 517 marks block bad
// [RULE_17] Never erase or program a bad block
// [RULE_18] Steer accesses away from bad blocks; only program and erase on a marked block are refused, reads still run
`ifndef NFH_CFG_SVH
`define NFH_CFG_SVH
`define NFH_CMD_PTR_MAIN 8'h00
`define NFH_CMD_PTR_SPARE 8'h50
`define NFH_CMD_PROG_LOAD 8'h80
`define NFH_CMD_PROG_GO 8'h10
`define NFH_CMD_ERASE_SETUP 8'h60
`define NFH_CMD_ERASE_GO 8'hD0
`define NFH_CMD_RESET 8'hFF
`define NFH_ERASED 8'hFF
`define NFH_BAD_COL 10'h005
`define NFH_NOP_MAIN 2'h2
`define NFH_NOP_SPARE 2'h3
`define NFH_CLK_NS 4
`define NFH_CYC_MIN(ns) (((ns) + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_T_WP_NS 25
`define NFH_T_WH_NS 25
`define NFH_T_RP_NS 50
`define NFH_T_WB_NS 100
`define NFH_T_CEH_NS 100
`define NFH_T_WP_CYC 8'(`NFH_CYC_MIN(`NFH_T_WP_NS))
`define NFH_T_WH_CYC 8'(`NFH_CYC_MIN(`NFH_T_WH_NS))
`define NFH_T_RP_CYC 8'(`NFH_CYC_MIN(`NFH_T_RP_NS))
`define NFH_T_WB_CYC 8'(`NFH_CYC_MIN(`NFH_T_WB_NS))
`define NFH_T_CEH_CYC 8'(`NFH_CYC_MIN(`NFH_T_CEH_NS))
`endif

// ### hw/nfh_pkg.sv
// Types and step decoding for the flash host sequencer
`include "nfh_cfg.svh"
package nfh_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_READ_SPARE = 3'h1, OP_PROG = 3'h2,
    OP_PROG_SPARE = 3'h3, OP_ERASE = 3'h4, OP_RESET = 3'h5
  } nfh_op_type;
  typedef enum logic [2:0] {
    K_CMD = 3'h0, K_ADDR = 3'h1, K_DATA = 3'h2, K_READ = 3'h3, K_WAIT = 3'h4, K_END = 3'h5
  } nfh_kind_type;
  typedef struct packed {
    nfh_kind_type kind;
    logic [7:0] b;
  } nfh_step_type;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_STEP = 6'h02, S_LOW = 6'h04, S_HIGH = 6'h08, S_WAIT = 6'h10, S_CEH = 6'h20
  } nfh_state_type;

  // Byte list per operation; a = {page[13:0], column[7:0]}
  function automatic nfh_step_type nfh_step(nfh_op_type op, logic [3:0] idx, logic [21:0] a);
    logic [7:0] ptr;
    nfh_step_type s;
    ptr = op[0] ? `NFH_CMD_PTR_SPARE : `NFH_CMD_PTR_MAIN;
    s = '{K_END, 8'h00};
    case (op)
      OP_READ, OP_READ_SPARE: begin
        case (idx)
          4'h0: s = '{K_CMD, ptr};
          4'h1: s = '{K_ADDR, a[7:0]};
          4'h2: s = '{K_ADDR, a[15:8]};
          4'h3: s = '{K_ADDR, {2'h0, a[21:16]}};
          4'h4: s = '{K_WAIT, 8'h00};
          4'h5: s = '{K_READ, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
      OP_PROG, OP_PROG_SPARE: begin
        case (idx)
          4'h0: s = '{K_CMD, ptr};
          4'h1: s = '{K_CMD, `NFH_CMD_PROG_LOAD};
          4'h2: s = '{K_ADDR, a[7:0]};
          4'h3: s = '{K_ADDR, a[15:8]};
          4'h4: s = '{K_ADDR, {2'h0, a[21:16]}};
          4'h5: s = '{K_DATA, 8'h00};
          4'h6: s = '{K_CMD, `NFH_CMD_PROG_GO};
          4'h7: s = '{K_WAIT, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
      OP_ERASE: begin
        case (idx)
          4'h0: s = '{K_CMD, `NFH_CMD_ERASE_SETUP};
          4'h1: s = '{K_ADDR, a[15:8]};
          4'h2: s = '{K_ADDR, {2'h0, a[21:16]}};
          4'h3: s = '{K_CMD, `NFH_CMD_ERASE_GO};
          4'h4: s = '{K_WAIT, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
      default: begin
        case (idx)
          4'h0: s = '{K_CMD, `NFH_CMD_RESET};
          4'h1: s = '{K_WAIT, 8'h00};
          default: s = '{K_END, 8'h00};
        endcase
      end
    endcase
    return s;
  endfunction : nfh_step
endpackage : nfh_pkg

// ### hw/nfh_ctrl.sv
// Flash host sequencer with read-data FIFO and bad-block table
`timescale 1ns/1ps
`default_nettype none
`include "nfh_cfg.svh"

module nfh_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [0:D-1];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  // Storage only; no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : nfh_fifo

module nfh_ctrl import nfh_pkg::*; #(
  parameter int NBLK = 1024,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Operation request
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_OP,
  input wire logic [21:0] CMD_ADDR,
  input wire logic [9:0] CMD_LEN,
  input wire logic CMD_SPARE_OFF,
  output logic CMD_READY,
  output logic DONE,
  output logic REFUSED,
  // Program data
  input wire logic [7:0] WR_DATA,
  input wire logic WR_VALID,
  output logic WR_READY,
  // Read data
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  input wire logic RD_READY,
  // Flash pins
  output logic FL_CLE,
  output logic FL_ALE,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_READ_STROBE_N,
  output logic FL_WP_N,
  output logic FL_SPARE_SEL,
  output logic [7:0] FL_IO_OUT,
  output logic FL_IO_OE,
  input wire logic [7:0] FL_IO_IN,
  input wire logic FL_RB
);
  nfh_state_type st_r;
  nfh_op_type op_r;
  nfh_step_type stp;
  logic [7:0] tmr_r, io_s1, io_s2, io_s3, io_st, push_data_r;
  logic [3:0] idx_r;
  logic [9:0] cnt_r, len_r, col_r;
  logic [21:0] addr_r;
  logic rb_s1, rb_s2, rb_s3, rb_st, push_r, fifo_in_ready, accept, refuse, prog_req;
  logic bad_r [0:NBLK-1];
  logic [13:0] pc_page_r;
  logic [1:0] pc_main_r, pc_spare_r;

  assign stp = nfh_step(op_r, idx_r, addr_r);
  assign prog_req = (CMD_OP == OP_PROG) || (CMD_OP == OP_PROG_SPARE);
  // Partial-program limit tracks only the most recent page
  assign refuse = ((prog_req || CMD_OP == OP_ERASE) && bad_r[CMD_ADDR[21:12]]) || // RULE_17 RULE_18
                  (prog_req && CMD_ADDR[21:8] == pc_page_r && (CMD_OP[0] ?
                   pc_spare_r == `NFH_NOP_SPARE : pc_main_r == `NFH_NOP_MAIN)); // RULE_09
  assign accept = (st_r == S_IDLE) && CMD_VALID && CMD_READY;

  // Pin inputs: three stages, change taken when stages two and three agree
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      {io_s1, io_s2, io_s3, io_st} <= '0;
      {rb_s1, rb_s2, rb_s3, rb_st} <= '0;
    end else begin
      io_s1 <= FL_IO_IN;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      rb_s1 <= FL_RB;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (io_s2 == io_s3) io_st <= io_s3;
      if (rb_s2 == rb_s3) rb_st <= rb_s3;
    end
  end

  // Sequencer and pin drive
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= S_IDLE;
      op_r <= OP_RESET;
      {tmr_r, idx_r, cnt_r, len_r, col_r, addr_r, push_data_r} <= '0;
      {DONE, REFUSED, WR_READY, push_r} <= '0;
      CMD_READY <= 1'b1;
      {FL_CLE, FL_ALE, FL_IO_OE, FL_WP_N, FL_SPARE_SEL} <= '0;
      {FL_CE_N, FL_WE_N, FL_READ_STROBE_N} <= 3'h7;
      FL_IO_OUT <= '0;
    end else begin
      DONE <= 1'b0;
      REFUSED <= 1'b0;
      WR_READY <= 1'b0;
      push_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (accept && refuse) begin
            REFUSED <= 1'b1;
          end else if (accept) begin
            CMD_READY <= 1'b0;
            op_r <= nfh_op_type'(CMD_OP);
            addr_r <= CMD_ADDR;
            col_r <= {2'h0, CMD_ADDR[7:0]};
            len_r <= (CMD_LEN == '0) ? 10'h001 : CMD_LEN;
            cnt_r <= (CMD_LEN == '0) ? 10'h001 : CMD_LEN;
            idx_r <= '0;
            FL_SPARE_SEL <= CMD_SPARE_OFF; // RULE_08
            FL_WP_N <= prog_req || (CMD_OP == OP_ERASE); // RULE_06
            FL_CE_N <= 1'b0; // RULE_05
            st_r <= S_STEP;
          end
        end
        S_STEP: begin
          case (stp.kind)
            K_CMD, K_ADDR: begin
              FL_CLE <= (stp.kind == K_CMD); // RULE_01
              FL_ALE <= (stp.kind == K_ADDR); // RULE_02
              FL_IO_OUT <= stp.b;
              FL_IO_OE <= 1'b1;
              FL_WE_N <= 1'b0;
              tmr_r <= `NFH_T_WP_CYC;
              st_r <= S_LOW;
            end
            K_DATA: begin
              // Stall until a byte is offered
              if (WR_VALID) begin
                FL_IO_OUT <= WR_DATA;
                FL_IO_OE <= 1'b1;
                FL_WE_N <= 1'b0;
                WR_READY <= 1'b1;
                tmr_r <= `NFH_T_WP_CYC;
                st_r <= S_LOW;
              end
            end
            K_READ: begin
              // FIFO back-pressure holds the read strobe high
              if (fifo_in_ready) begin
                FL_IO_OE <= 1'b0;
                FL_READ_STROBE_N <= 1'b0; // RULE_03 RULE_05
                tmr_r <= `NFH_T_RP_CYC;
                st_r <= S_LOW;
              end
            end
            K_WAIT: begin
              FL_IO_OE <= 1'b0;
              tmr_r <= `NFH_T_WB_CYC;
              st_r <= S_WAIT;
            end
            default: begin
              // Read stops after len_r bytes; no busy wait is taken at a page end
              FL_CE_N <= 1'b1; // RULE_10 RULE_11
              FL_WP_N <= 1'b0;
              FL_IO_OE <= 1'b0;
              tmr_r <= `NFH_T_CEH_CYC;
              st_r <= S_CEH;
            end
          endcase
        end
        S_LOW: begin
          if (tmr_r == '0) begin
            FL_WE_N <= 1'b1;
            FL_READ_STROBE_N <= 1'b1;
            if (stp.kind == K_READ) begin
              push_r <= 1'b1;
              push_data_r <= io_st; // RULE_03
              col_r <= col_r + 10'h001;
            end
            tmr_r <= `NFH_T_WH_CYC;
            st_r <= S_HIGH;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        S_HIGH: begin
          if (tmr_r == '0) begin
            FL_CLE <= 1'b0;
            FL_ALE <= 1'b0;
            if ((stp.kind == K_DATA || stp.kind == K_READ) && cnt_r > 10'h001) begin
              cnt_r <= cnt_r - 10'h001;
            end else begin
              cnt_r <= len_r;
              idx_r <= idx_r + 4'h1;
            end
            st_r <= S_STEP;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        S_WAIT: begin
          // Chip select stays low through the load, so no abort occurs
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 8'h01;
          end else if (rb_st) begin
            idx_r <= idx_r + 4'h1; // RULE_04 RULE_07 RULE_12 RULE_13
            st_r <= S_STEP;
          end
        end
        S_CEH: begin
          if (tmr_r == '0) begin
            CMD_READY <= 1'b1; // RULE_11
            DONE <= 1'b1;
            st_r <= S_IDLE;
          end else begin
            tmr_r <= tmr_r - 8'h01;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Bad-block table built from marker reads; block zero is never marked
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NBLK; i++) bad_r[i] <= 1'b0;
    end else if (st_r == S_LOW && tmr_r == '0 && stp.kind == K_READ && op_r == OP_READ_SPARE &&
                 col_r == `NFH_BAD_COL && addr_r[11:9] == 3'h0 && io_st != `NFH_ERASED &&
                 addr_r[21:12] != 10'h000) begin
      bad_r[addr_r[21:12]] <= 1'b1; // RULE_14 RULE_15 RULE_16
    end
  end

  // Partial-program counts for the last page, cleared by erasing its block
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pc_page_r <= '0;
      pc_main_r <= '0;
      pc_spare_r <= '0;
    end else if (accept && !refuse && prog_req) begin
      pc_page_r <= CMD_ADDR[21:8];
      if (CMD_ADDR[21:8] != pc_page_r) begin
        pc_main_r <= CMD_OP[0] ? 2'h0 : 2'h1;
        pc_spare_r <= CMD_OP[0] ? 2'h1 : 2'h0;
      end else if (CMD_OP[0]) begin
        pc_spare_r <= pc_spare_r + 2'h1; // RULE_09
      end else begin
        pc_main_r <= pc_main_r + 2'h1;
      end
    end else if (accept && !refuse && CMD_OP == OP_ERASE && CMD_ADDR[21:12] == pc_page_r[13:4]) begin
      pc_main_r <= '0;
      pc_spare_r <= '0;
    end
  end

  nfh_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(push_data_r),
    .out_valid(RD_VALID),
    .out_ready(RD_READY),
    .out_data(RD_DATA)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_we_pulse_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*8]) // RULE_01
    else $error("write strobe low too short");
  a_latch_exclusive: assert property (!(FL_CLE && FL_ALE)) // RULE_05
    else $error("both latch enables high");
  a_addr_on_rise: assert property ($rose(FL_WE_N) && FL_ALE |-> FL_IO_OE && !FL_CE_N) // RULE_02
    else $error("address latched without drive");
  a_read_bus_free: assert property ($fell(FL_READ_STROBE_N) |-> !FL_IO_OE && !FL_CLE && !FL_ALE) // RULE_03
    else $error("read strobe with bus driven");
  a_wp_go_cmd: assert property ($fell(FL_WE_N) && FL_CLE && FL_IO_OUT == `NFH_CMD_PROG_GO |-> FL_WP_N) // RULE_06
    else $error("program start while protected");
  a_busy_quiet: assert property (st_r == S_WAIT && !rb_st |=> FL_WE_N && FL_READ_STROBE_N && !FL_CE_N) // RULE_04
    else $error("strobes moved while busy");
  a_ceh_hold: assert property ($rose(FL_CE_N) |-> FL_CE_N [*8] ##1 FL_CE_N [*8] ##1 FL_CE_N [*8]) // RULE_11
    else $error("chip select end hold short");
  a_bad_refuse: assert property (accept && (prog_req || CMD_OP == OP_ERASE) && bad_r[CMD_ADDR[21:12]]
    |=> REFUSED && CMD_READY && FL_CE_N) // RULE_17
    else $error("bad block not refused");
  a_block0_good: assert property (!bad_r[0]) // RULE_14
    else $error("block zero marked bad");
  a_prog_limit: assert property (pc_main_r <= `NFH_NOP_MAIN && pc_spare_r <= `NFH_NOP_SPARE) // RULE_09
    else $error("partial program count exceeded");
  c_read_done: cover property (op_r == OP_READ && DONE);
  c_prog_done: cover property (op_r == OP_PROG && DONE);
  c_fifo_stall: cover property (stp.kind == K_READ && st_r == S_STEP && !fifo_in_ready);
  c_refused: cover property (REFUSED);
endmodule : nfh_ctrl
`default_nettype wire

// ### testbench/nfh_flash_model.sv
// Behavioural flash device answering the host sequencer's pins
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model #(
  parameter int BAD_PAGE = 48
) (
  // Control pins
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic spare_sel,
  // Data bus and status
  input wire logic [7:0] io,
  output logic [7:0] dout,
  output logic rb
);
  logic [7:0] mem [int];
  logic [7:0] cmd, last;
  logic [13:0] page;
  logic [7:0] col;
  logic area;
  int aidx, k;
  time blen;
  event go;
  function automatic int key(logic a, logic [13:0] p, logic [7:0] c);
    return int'({a, p, c});
  endfunction : key
  // Unwritten cells read erased
  function automatic logic [7:0] rd(int kk);
    return mem.exists(kk) ? mem[kk] : 8'hFF;
  endfunction : rd
  // Factory mark on one block only; block zero stays clean
  initial begin
    rb = 1'b1;
    dout = 8'hFF;
    last = 8'h00;
    area = 1'b0;
    aidx = 0;
    mem[key(1'b1, 14'(BAD_PAGE), 8'h05)] = 8'h00;
  end
  // Busy window; times scaled well under the maxima
  always @(go) begin
    rb = 1'b0;
    #(blen) rb = 1'b1;
  end
  // Command, address and data capture on write strobe rise
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      cmd = io;
      aidx = (io == 8'h60) ? 1 : 0;
      if (io == 8'h00) area = 1'b0;
      if (io == 8'h50) area = 1'b1;
      if (io == 8'h10 && wp_n) begin
        blen = 3000;
        ->go;
      end
      if (io == 8'hD0 && wp_n) begin
        for (int i = 0; i < 8192; i++) begin
          k = key(i[12], {page[13:4], i[11:8]}, i[7:0]);
          if (mem.exists(k)) mem.delete(k);
        end
        blen = 4000;
        ->go;
      end
      if (io == 8'hFF) begin
        blen = 1000;
        ->go;
      end
    end else if (ale) begin
      if (aidx == 0) col = io;
      else if (aidx == 1) page[7:0] = io;
      else page[13:8] = io[5:0];
      aidx++;
      if (aidx == 3 && cmd != 8'h80 && cmd != 8'h60) begin
        blen = 2000;
        ->go;
      end
    end else if (cmd == 8'h80 && !(area && spare_sel)) begin
      mem[key(area, page, col)] = rd(key(area, page, col)) & io;
      col++;
    end
  end
  // Byte out on read strobe fall, column advances
  always @(negedge read_strobe_n) if (!ce_n) begin
    #20 last = (area && spare_sel) ? 8'hFF : rd(key(area, page, col));
    dout = last;
    col++;
  end
  // Released bus shows no stale byte
  always @(posedge read_strobe_n or posedge ce_n) #15 dout = ~last;
endmodule : nfh_flash_model
`default_nettype wire

// ### testbench/nfh_ctrl_tb_top.sv
// Testbench for the flash host sequencer against the flash model
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl_tb_top;
  logic CLK_SYS, RST_N, CMD_VALID, CMD_SPARE_OFF, WR_VALID, RD_READY, CMD_READY, DONE, REFUSED, WR_READY;
  logic RD_VALID, FL_CLE, FL_ALE, FL_CE_N, FL_WE_N, FL_RS_N, FL_WP_N, FL_SPARE_SEL, FL_IO_OE, FL_RB;
  logic [2:0] CMD_OP;
  logic [21:0] CMD_ADDR;
  logic [9:0] CMD_LEN;
  logic [7:0] WR_DATA, RD_DATA, FL_IO_OUT, dev_out;
  wire [7:0] bus;
  int error_cnt = 0, tests_run = 0, cyc = 0, rb_falls = 0;
  bit got_ref, wp_hi, ss_hi;
  logic [7:0] rq[$], wq[$];
  assign bus = FL_IO_OE ? FL_IO_OUT : dev_out;
  nfh_ctrl nfh_ctrl_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN), .CMD_SPARE_OFF(CMD_SPARE_OFF), .CMD_READY(CMD_READY),
    .DONE(DONE), .REFUSED(REFUSED), .WR_DATA(WR_DATA), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .FL_CLE(FL_CLE), .FL_ALE(FL_ALE),
    .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_READ_STROBE_N(FL_RS_N), .FL_WP_N(FL_WP_N),
    .FL_SPARE_SEL(FL_SPARE_SEL), .FL_IO_OUT(FL_IO_OUT), .FL_IO_OE(FL_IO_OE), .FL_IO_IN(bus), .FL_RB(FL_RB));
  nfh_flash_model nfh_flash_model_i (.cle(FL_CLE), .ale(FL_ALE), .ce_n(FL_CE_N), .we_n(FL_WE_N),
    .read_strobe_n(FL_RS_N), .wp_n(FL_WP_N), .spare_sel(FL_SPARE_SEL), .io(bus), .dout(dev_out), .rb(FL_RB));
  // 250 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  // Hang guard; whole run is well under this
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Busy pulses seen on the ready line
  always @(negedge FL_RB) rb_falls++;
  // Program data presented from the queue head
  always @(posedge CLK_SYS) begin
    WR_VALID <= wq.size() > 0;
    WR_DATA <= (wq.size() > 0) ? wq[0] : 8'h00;
  end
  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin error_cnt++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin error_cnt++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end
  endtask : chk8
  task automatic chkn(input int g, input int e);
    tests_run++;
    if (g != e) begin error_cnt++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end
  endtask : chkn
  task automatic chk_rq(input logic [7:0] e[$]);
    chkn(rq.size(), e.size());
    foreach (e[i]) if (i < rq.size()) chk8(rq[i], e[i]);
  endtask : chk_rq
  // One request, then collect bytes until done or refused; hold stalls the read side
  task automatic run_op(input logic [2:0] op, input logic [21:0] a, input logic [9:0] len, input logic soff,
    input int hold);
    int n;
    bit fin;
    rq = {}; got_ref = 0; wp_hi = 0; ss_hi = 0; fin = 0; n = 0;
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b1; CMD_OP <= op; CMD_ADDR <= a; CMD_LEN <= len; CMD_SPARE_OFF <= soff; RD_READY <= hold == 0;
    @(posedge CLK_SYS);
    CMD_VALID <= 1'b0;
    while (!fin && n < 20000) begin
      @(negedge CLK_SYS);
      n++;
      fin = (DONE === 1'b1) || (REFUSED === 1'b1);
      got_ref |= REFUSED === 1'b1;
      wp_hi |= FL_WP_N === 1'b1;
      ss_hi |= FL_SPARE_SEL === 1'b1;
      if (RD_VALID === 1'b1 && RD_READY === 1'b1) rq.push_back(RD_DATA);
      if (WR_READY === 1'b1 && wq.size() > 0) void'(wq.pop_front());
      if (n == hold) begin
        chk1(RD_VALID, 1'b1);
        chk1(fin, 1'b0);
        @(posedge CLK_SYS);
        RD_READY <= 1'b1;
      end
    end
    chk1(fin, 1'b1);
    @(posedge CLK_SYS);
  endtask : run_op
  task automatic t_bad_block();
    run_op(3'h1, {14'd48, 8'h00}, 10'd6, 1'b0, 0);
    chk1(ss_hi, 1'b0);
    chk_rq('{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00});
    run_op(3'h2, {14'd50, 8'h00}, 10'd1, 1'b0, 0);
    chk1(got_ref, 1'b1);
    run_op(3'h4, {14'd48, 8'h00}, 10'd1, 1'b0, 0);
    chk1(got_ref, 1'b1);
  endtask : t_bad_block
  task automatic t_program();
    int f;
    f = rb_falls;
    wq = '{8'hA5, 8'h3C, 8'h0F, 8'h81};
    run_op(3'h2, {14'd0, 8'h10}, 10'd4, 1'b0, 0);
    chk1(got_ref, 1'b0);
    chk1(wp_hi, 1'b1);
    chkn(rb_falls, f + 1);
    run_op(3'h0, {14'd0, 8'h10}, 10'd4, 1'b0, 0);
    chk1(wp_hi, 1'b0);
    chk_rq('{8'hA5, 8'h3C, 8'h0F, 8'h81});
    chkn(rb_falls, f + 2);
    wq = '{8'hFF};
    run_op(3'h2, {14'd0, 8'h10}, 10'd1, 1'b0, 0);
    chk1(got_ref, 1'b0);
    wq = '{8'hFF};
    run_op(3'h2, {14'd0, 8'h10}, 10'd1, 1'b0, 0);
    chk1(got_ref, 1'b1);
    wq = {};
  endtask : t_program
  task automatic t_erase_fifo();
    logic [7:0] e[$];
    run_op(3'h4, {14'd0, 8'h00}, 10'd1, 1'b0, 0);
    chk1(wp_hi, 1'b1);
    wq = '{8'h11};
    run_op(3'h2, {14'd0, 8'h10}, 10'd1, 1'b0, 0);
    chk1(got_ref, 1'b0);
    e = '{8'h11};
    repeat (39) e.push_back(8'hFF);
    run_op(3'h0, {14'd0, 8'h10}, 10'd40, 1'b0, 3000);
    chk_rq(e);
  endtask : t_erase_fifo
  task automatic t_spare_off();
    run_op(3'h1, {14'd48, 8'h00}, 10'd6, 1'b1, 0);
    chk1(ss_hi, 1'b1);
    chk_rq('{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
  endtask : t_spare_off
  task automatic t_reset();
    int f;
    f = rb_falls;
    run_op(3'h5, 22'h000000, 10'd1, 1'b0, 0);
    chk1(got_ref, 1'b0);
    chkn(rb_falls, f + 1);
  endtask : t_reset
  task automatic report_and_stop();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    RST_N = 1'b0; CMD_VALID = 1'b0; CMD_OP = 3'h0; CMD_ADDR = 22'h000000; CMD_LEN = 10'h000;
    CMD_SPARE_OFF = 1'b0; RD_READY = 1'b1; WR_VALID = 1'b0; WR_DATA = 8'h00;
    repeat (8) @(posedge CLK_SYS);
    chk1(CMD_READY, 1'b1);
    chk1(FL_CE_N, 1'b1);
    chk1(FL_WP_N, 1'b0);
    RST_N <= 1'b1;
    t_bad_block();
    t_program();
    t_erase_fifo();
    t_spare_off();
    t_reset();
    report_and_stop();
  end
endmodule : nfh_ctrl_tb_top
`default_nettype wire
